// file: ors_pkg.sv
// Purpose: shared constants for the output range and event status register bank
// Assumes: byte addresses as seen by the device's command decoder
// Notes:   fault bit positions are common to every event register

package ors_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [15:0] ORS_ADDR_FLAGS   = 16'h001c;
	localparam logic [15:0] ORS_ADDR_RANGE   = 16'h0048;
	localparam logic [15:0] ORS_ADDR_ENABLE  = 16'h008a;
	localparam logic [15:0] ORS_ADDR_CLEAR   = 16'h00a0;

	// ****************************************
	// range register fields
	// ****************************************
	localparam int          ORS_RANGE_VOLT_LSB  = 0;
	localparam int          ORS_RANGE_CURR_LSB  = 8;
	localparam int          ORS_RANGE_POWER_LSB = 16;
	localparam int          ORS_COUNT_W         = 8;
	localparam logic [23:0] ORS_RANGE_RESET     = 24'h00_0000;

	// ****************************************
	// event register fields
	// ****************************************
	localparam int          ORS_NUM_FAULTS   = 10;
	localparam int          ORS_FAULT_LSB    = 6;
	localparam logic [9:0]  ORS_FLAGS_RESET  = 10'h000;
	localparam int          ORS_BIT_SURGE    = 6;
	localparam int          ORS_BIT_SAG      = 7;
	localparam int          ORS_BIT_UNDTEMP  = 8;
	localparam int          ORS_BIT_OVRTEMP  = 9;
	localparam int          ORS_BIT_UNDFREQ  = 10;
	localparam int          ORS_BIT_OVRFREQ  = 11;
	localparam int          ORS_BIT_UNDVOLT  = 12;
	localparam int          ORS_BIT_OVRPOWER = 13;
	localparam int          ORS_BIT_OVRVOLT  = 14;
	localparam int          ORS_BIT_OVRCURR  = 15;

	// ****************************************
	// measurement path
	// ****************************************
	localparam int          ORS_MEAS_W       = 32;
	localparam int          ORS_NUM_CH       = 4;
	localparam int          ORS_CH_VOLT      = 0;
	localparam int          ORS_CH_CURR      = 1;
	localparam int          ORS_CH_PACT      = 2;
	localparam int          ORS_CH_PREACT    = 3;
	localparam logic [31:0] ORS_MEAS_RESET   = 32'h0000_0000;

	typedef enum logic [1:0] {
		ORS_SEL_NONE   = 2'b00,
		ORS_SEL_FLAGS  = 2'b01,
		ORS_SEL_RANGE  = 2'b10,
		ORS_SEL_ENABLE = 2'b11
	} ors_sel_t;

endpackage

// file: ors_range_shift.sv
// Purpose: one output scaling stage, a right shift by a programmed count
// Assumes: raw sample and count are on the core clock
// Notes:   counts of 32 or more give zero, as a logical shift does

`timescale 1ns/10ps

module ors_range_shift
	import ors_pkg::*;
(
	input  wire logic                   i_core_clk,
	input  wire logic                   i_reset_n,
	input  wire logic [ORS_MEAS_W-1:0]  i_raw,
	input  wire logic                   i_raw_valid,
	input  wire logic [ORS_COUNT_W-1:0] i_count,
	output logic      [ORS_MEAS_W-1:0]  o_scaled,
	output logic                        o_scaled_valid
);

	// ****************************************
	// shift and hold
	// ****************************************
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_scaled <= ORS_MEAS_RESET;
		end else if (i_raw_valid) begin
			o_scaled <= i_raw >> i_count; // [R2]
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_scaled_valid <= 1'b0;
		end else begin
			o_scaled_valid <= i_raw_valid;
		end
	end

endmodule

// file: ors_regbank.sv
// Purpose: output range register and event enable/flag registers
// Assumes: command decoder, limit/hold logic and fault detectors share i_core_clk
// Notes:   reads answer one cycle after the strobe; unmapped reads return zero
//
// Contract
// [R1] a 32-bit range register holds right-shift counts in byte fields
// [R2] each output is its result shifted right by its count
// [R3] bits 23..16 scale both active and reactive power outputs
// [R4] bits 15..8 scale the rms current output
// [R5] bits 7..0 scale the rms voltage output
// [R6] top byte reads zero; all counts reset to zero
// [R7] host picks counts that avoid overflow yet keep resolution
// [R8] enable register shows per-fault detection enable; bits 5..0 read zero
// [R9] fault bits sit at fixed positions 15 down to 6
// [R10] read-only flag register latches occurred faults; resets to zero
// [R11] a flag drops only once fault has ended and host cleared it
// [R12] only enabled fault types may set their flag

`timescale 1ns/10ps

module ors_regbank
	import ors_pkg::*;
(
	input  wire logic                      i_core_clk,
	input  wire logic                      i_reset_n,
	input  wire logic                      i_reg_wr,
	input  wire logic                      i_reg_rd,
	input  wire logic [15:0]               i_reg_addr,
	input  wire logic [31:0]               i_reg_wdata,
	output logic      [31:0]               o_reg_rdata,
	output logic                           o_reg_rvalid,
	input  wire logic [ORS_NUM_FAULTS-1:0] i_fault_enable_cfg,
	input  wire logic [ORS_NUM_FAULTS-1:0] i_fault_active,
	input  wire logic [ORS_MEAS_W-1:0]     i_volt_rms_raw,
	input  wire logic [ORS_MEAS_W-1:0]     i_curr_rms_raw,
	input  wire logic [ORS_MEAS_W-1:0]     i_power_act_raw,
	input  wire logic [ORS_MEAS_W-1:0]     i_power_react_raw,
	input  wire logic                      i_meas_valid,
	output logic      [ORS_MEAS_W-1:0]     o_volt_rms,
	output logic      [ORS_MEAS_W-1:0]     o_curr_rms,
	output logic      [ORS_MEAS_W-1:0]     o_power_act,
	output logic      [ORS_MEAS_W-1:0]     o_power_react,
	output logic                           o_meas_valid,
	output logic      [15:0]               o_fault_flags
);

	// ****************************************
	// address decode
	// ****************************************
	function automatic ors_sel_t ors_decode(input logic [15:0] addr);
		ors_sel_t sel;
		sel = ORS_SEL_NONE;
		if (addr == ORS_ADDR_FLAGS) begin
			sel = ORS_SEL_FLAGS;
		end else if (addr == ORS_ADDR_RANGE) begin
			sel = ORS_SEL_RANGE;
		end else if (addr == ORS_ADDR_ENABLE) begin
			sel = ORS_SEL_ENABLE;
		end
		return sel;
	endfunction

	ors_sel_t                  wr_sel;
	ors_sel_t                  rd_sel;
	logic                      clear_wr;
	logic [23:0]               range_reg;
	logic [ORS_NUM_FAULTS-1:0] enable_reg;
	logic [ORS_NUM_FAULTS-1:0] flags_reg;
	logic [ORS_NUM_FAULTS-1:0] flags_next;
	logic [ORS_NUM_FAULTS-1:0] clear_bits;

	assign wr_sel     = i_reg_wr ? ors_decode(i_reg_addr) : ORS_SEL_NONE;
	assign rd_sel     = i_reg_rd ? ors_decode(i_reg_addr) : ORS_SEL_NONE;
	assign clear_wr   = i_reg_wr && (i_reg_addr == ORS_ADDR_CLEAR);
	assign clear_bits = clear_wr ? i_reg_wdata[ORS_FAULT_LSB +: ORS_NUM_FAULTS]
		: '0;

	// ****************************************
	// range register
	// ****************************************
	// top byte has no storage at all, so it cannot read back anything but zero
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			range_reg <= ORS_RANGE_RESET; // [R6]
		end else if (wr_sel == ORS_SEL_RANGE) begin
			range_reg <= i_reg_wdata[23:0]; // [R1]
		end
	end

	// ****************************************
	// event enable status
	// ****************************************
	// limit/hold logic owns the enables; this is a read-only mirror of it
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			enable_reg <= ORS_FLAGS_RESET;
		end else begin
			enable_reg <= i_fault_enable_cfg; // [R8]
		end
	end

	// ****************************************
	// event occurrence flags
	// ****************************************
	// a clear while the fault is still present is ignored, and a new set
	// in the clearing cycle wins, so no event is ever lost
	always_comb begin
		flags_next = (flags_reg & ~(clear_bits & ~i_fault_active)) // [R11]
			| (i_fault_active & enable_reg); // [R12]
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			flags_reg <= ORS_FLAGS_RESET; // [R10]
		end else begin
			flags_reg <= flags_next; // [R10]
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_fault_flags <= 16'h0000;
		end else begin
			o_fault_flags <= {flags_next, 6'h00}; // [R9]
		end
	end

	// ****************************************
	// register read
	// ****************************************
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_reg_rdata <= 32'h0000_0000;
		end else if (i_reg_rd) begin
			unique case (rd_sel)
				ORS_SEL_FLAGS:  o_reg_rdata <= {16'h0000, flags_reg, 6'h00}; // [R9]
				ORS_SEL_RANGE:  o_reg_rdata <= {8'h00, range_reg}; // [R6]
				ORS_SEL_ENABLE: o_reg_rdata <= {16'h0000, enable_reg, 6'h00}; // [R8]
				ORS_SEL_NONE:   o_reg_rdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
		end
	end

	// ****************************************
	// output scaling
	// ****************************************
	// counts come straight from the register; choosing them sanely is software's job
	logic [ORS_MEAS_W-1:0]  ch_raw    [ORS_NUM_CH];
	logic [ORS_COUNT_W-1:0] ch_count  [ORS_NUM_CH];
	logic [ORS_MEAS_W-1:0]  ch_scaled [ORS_NUM_CH];
	logic [ORS_NUM_CH-1:0]  ch_valid;

	assign ch_raw[ORS_CH_VOLT]     = i_volt_rms_raw;
	assign ch_raw[ORS_CH_CURR]     = i_curr_rms_raw;
	assign ch_raw[ORS_CH_PACT]     = i_power_act_raw;
	assign ch_raw[ORS_CH_PREACT]   = i_power_react_raw;
	assign ch_count[ORS_CH_VOLT]   = range_reg[ORS_RANGE_VOLT_LSB +: ORS_COUNT_W]; // [R5]
	assign ch_count[ORS_CH_CURR]   = range_reg[ORS_RANGE_CURR_LSB +: ORS_COUNT_W]; // [R4]
	assign ch_count[ORS_CH_PACT]   = range_reg[ORS_RANGE_POWER_LSB +: ORS_COUNT_W]; // [R3]
	assign ch_count[ORS_CH_PREACT] = range_reg[ORS_RANGE_POWER_LSB +: ORS_COUNT_W]; // [R3]

	generate
		for (genvar ch = 0; ch < ORS_NUM_CH; ch++) begin : g_ch
			ors_range_shift u_shift (
				.i_core_clk     (i_core_clk),
				.i_reset_n      (i_reset_n),
				.i_raw          (ch_raw[ch]),
				.i_raw_valid    (i_meas_valid),
				.i_count        (ch_count[ch]),
				.o_scaled       (ch_scaled[ch]),
				.o_scaled_valid (ch_valid[ch])
			);
		end
	endgenerate

	assign o_volt_rms    = ch_scaled[ORS_CH_VOLT];
	assign o_curr_rms    = ch_scaled[ORS_CH_CURR];
	assign o_power_act   = ch_scaled[ORS_CH_PACT];
	assign o_power_react = ch_scaled[ORS_CH_PREACT];
	assign o_meas_valid  = ch_valid[ORS_CH_VOLT];

endmodule

// file: ors_regbank_checker.sv
// Purpose: port checks for the range and event register bank
// Assumes: one clock, asynchronous active-low reset
// Notes:   o_fault_flags is taken to show the flag register itself
`timescale 1ns/10ps
module ors_regbank_checker
	import ors_pkg::*;
(
	input wire logic                      i_core_clk,
	input wire logic                      i_reset_n,
	input wire logic                      i_reg_wr,
	input wire logic                      i_reg_rd,
	input wire logic [15:0]               i_reg_addr,
	input wire logic [31:0]               i_reg_wdata,
	input wire logic [31:0]               o_reg_rdata,
	input wire logic                      o_reg_rvalid,
	input wire logic [ORS_NUM_FAULTS-1:0] i_fault_enable_cfg,
	input wire logic [ORS_NUM_FAULTS-1:0] i_fault_active,
	input wire logic                      i_meas_valid,
	input wire logic                      o_meas_valid,
	input wire logic [15:0]               o_fault_flags
);
	// a clear only counts for faults that have already passed
	logic [9:0] clr;
	logic       clr_wr;
	assign clr_wr = i_reg_wr && (i_reg_addr == ORS_ADDR_CLEAR);
	assign clr    = clr_wr ? (i_reg_wdata[15:6] & ~i_fault_active) : 10'h000;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	property p_rvalid; i_reg_rd |=> o_reg_rvalid; endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");
	property p_norv; !i_reg_rd |=> !o_reg_rvalid && $stable(o_reg_rdata); endproperty
	a_norv: assert property (p_norv) else $error("read data moved without read");
	property p_top;
		i_reg_rd && i_reg_addr == ORS_ADDR_RANGE |=> o_reg_rdata[31:24] == 8'h00;
	endproperty
	a_top: assert property (p_top) else $error("range top byte not zero");
	// the enable mirror still holds its reset value on the first edge after release
	property p_enrd;
		i_reg_rd && i_reg_addr == ORS_ADDR_ENABLE |=>
			o_reg_rdata == ($past(i_reset_n, 2)
				? {16'h0000, $past(i_fault_enable_cfg, 2), 6'h00}
				: 32'h0000_0000);
	endproperty
	a_enrd: assert property (p_enrd) else $error("enable readback wrong");
	property p_flrd;
		i_reg_rd && i_reg_addr == ORS_ADDR_FLAGS |=>
			o_reg_rdata == {16'h0000, $past(o_fault_flags)};
	endproperty
	a_flrd: assert property (p_flrd) else $error("flag readback wrong");
	property p_low; o_fault_flags[5:0] == 6'h00; endproperty
	a_low: assert property (p_low) else $error("unused flag bits set");
	property p_keep;
		1'b1 |=> ($past(o_fault_flags[15:6]) & ~$past(clr) & ~o_fault_flags[15:6]) == 10'h000;
	endproperty
	a_keep: assert property (p_keep) else $error("flag dropped without clear");
	property p_set;
		1'b1 |=> o_fault_flags[15:6] == (($past(o_fault_flags[15:6]) & ~$past(clr))
			| ($past(i_fault_active) & $past(i_fault_enable_cfg, 2)
			& {10{$past(i_reset_n, 2)}}));
	endproperty
	a_set: assert property (p_set) else $error("flag set wrong");
	property p_meas; i_meas_valid |=> o_meas_valid; endproperty
	a_meas: assert property (p_meas) else $error("scaled result not flagged");
	property p_measidle; !i_meas_valid |=> !o_meas_valid; endproperty
	a_measidle: assert property (p_measidle) else $error("scaled valid without input");
endmodule
bind ors_regbank ors_regbank_checker chk (.i_core_clk, .i_reset_n, .i_reg_wr, .i_reg_rd,
	.i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_fault_enable_cfg,
	.i_fault_active, .i_meas_valid, .o_meas_valid, .o_fault_flags);

// file: ors_host.sv
// Purpose: host controller model on the register port
// Assumes: strobes change on the falling edge
// Notes:   idle address and data are inverted so stale values never pass
`timescale 1ns/10ps
module ors_host (
	input  wire logic        i_core_clk,
	output logic             o_reg_wr,
	output logic             o_reg_rd,
	output logic      [15:0] o_reg_addr,
	output logic      [31:0] o_reg_wdata,
	input  wire logic [31:0] i_reg_rdata,
	input  wire logic        i_reg_rvalid
);
	logic last_vld = 1'b0;
	initial begin
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
		o_reg_addr = 16'h0000;
		o_reg_wdata = 32'h0000_0000;
	end
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(negedge i_core_clk);
		o_reg_addr = a;
		o_reg_wdata = d;
		o_reg_wr = 1'b1;
		@(negedge i_core_clk);
		o_reg_wr = 1'b0;
		o_reg_addr = ~a;
		o_reg_wdata = ~d;
	endtask
	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		@(negedge i_core_clk);
		o_reg_addr = a;
		o_reg_rd = 1'b1;
		@(negedge i_core_clk);
		o_reg_rd = 1'b0;
		o_reg_addr = ~a;
		@(posedge i_core_clk);
		d = i_reg_rdata;
		last_vld = i_reg_rvalid;
		// hand back off the sampling edge so the caller never races the design
		@(negedge i_core_clk);
	endtask
endmodule

// file: output_range_and_event_status_test.sv
// Purpose: self-checking bench for the range and event register bank
// Assumes: host model owns the register port
// Notes:   fault flags are modelled in fl
`timescale 1ns/10ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin mismatches++; \
	$display("unexpected %s exp %h got %h", n, e, a); end end
module output_range_and_event_status_test;
	import ors_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        wr, rd, ovld, rvld;
	logic        mv = 1'b0;
	logic [15:0] addr, flags;
	logic [31:0] wd, rdat, d;
	logic [9:0]  cfg = 10'h000;
	logic [9:0]  act = 10'h000;
	logic [9:0]  fl = 10'h000;
	logic [9:0]  m;
	logic [7:0]  v, c, p;
	logic [31:0] raw [4] = '{default: 32'h0000_0000};
	logic [31:0] out [4];
	int          seed = 32'hdb01_ec4f;
	int          mismatches = 0;
	int          compares = 0;
	always #12.5 clk = ~clk;
	ors_host hst (.i_core_clk(clk), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
		.o_reg_wdata(wd), .i_reg_rdata(rdat), .i_reg_rvalid(rvld));
	ors_regbank uut (.i_core_clk(clk), .i_reset_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_rvalid(rvld),
		.i_fault_enable_cfg(cfg), .i_fault_active(act), .i_volt_rms_raw(raw[0]),
		.i_curr_rms_raw(raw[1]), .i_power_act_raw(raw[2]), .i_power_react_raw(raw[3]),
		.i_meas_valid(mv), .o_volt_rms(out[0]), .o_curr_rms(out[1]), .o_power_act(out[2]),
		.o_power_react(out[3]), .o_meas_valid(ovld), .o_fault_flags(flags));
	function automatic logic [31:0] shr(input logic [31:0] x, input logic [7:0] n);
		return x >> n;
	endfunction
	task automatic results;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#(25 * 4000);
		mismatches++;
		results;
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		hst.rd(ORS_ADDR_RANGE, d);
		`CHK("range", 32'h0000_0000, d)
		`CHK("rvalid", 1'b1, hst.last_vld)
		hst.rd(ORS_ADDR_CLEAR, d);
		`CHK("clear", 32'h0000_0000, d)
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			v = (i < 2) ? {3'b000, {5{i[0]}}} : 8'($random(seed)) & 8'h1f;
			c = 8'($random(seed));
			p = 8'($random(seed));
			hst.wr(ORS_ADDR_RANGE, {8'hff, p, c, v});
			hst.rd(ORS_ADDR_RANGE, d);
			`CHK("range", {8'h00, p, c, v}, d)
			@(negedge clk);
			foreach (raw[k]) raw[k] = $random(seed);
			mv = 1'b1;
			@(negedge clk);
			mv = 1'b0;
			`CHK("volt", shr(raw[0], v), out[0])
			`CHK("curr", shr(raw[1], c), out[1])
			`CHK("pact", shr(raw[2], p), out[2])
			`CHK("preact", shr(raw[3], p), out[3])
			`CHK("mvalid", 1'b1, ovld)
		end
		$display("test scaling done");
		for (int i = 0; i < 5; i++) begin
			cfg = (i == 0) ? 10'h3ff : 10'($random(seed));
			@(negedge clk);
			hst.rd(ORS_ADDR_ENABLE, d);
			`CHK("enable", {16'h0000, cfg, 6'h00}, d)
			act = 10'($random(seed)) | 10'h201;
			fl = fl | (act & cfg);
			@(negedge clk);
			act = fl;
			`CHK("flagport", {fl, 6'h00}, flags)
			hst.wr(ORS_ADDR_CLEAR, {16'h0000, 10'h3ff, 6'h00});
			act = 10'h000;
			hst.rd(ORS_ADDR_FLAGS, d);
			`CHK("flags", {16'h0000, fl, 6'h00}, d)
			m = (i == 4) ? 10'h3ff : 10'($random(seed));
			hst.wr(ORS_ADDR_CLEAR, {16'h0000, m, 6'h00});
			fl = fl & ~m;
			hst.rd(ORS_ADDR_FLAGS, d);
			`CHK("cleared", {16'h0000, fl, 6'h00}, d)
		end
		// a fault that rises in the very cycle of a clear must survive it
		cfg = 10'h3ff;
		fork
			hst.wr(ORS_ADDR_CLEAR, 32'h0000_ffc0);
			begin
				@(negedge clk);
				act = 10'h001;
				@(negedge clk);
				act = 10'h000;
			end
		join
		fl = 10'h001;
		hst.rd(ORS_ADDR_FLAGS, d);
		`CHK("setwins", {16'h0000, fl, 6'h00}, d)
		hst.wr(ORS_ADDR_FLAGS, 32'hffff_ffff);
		hst.wr(ORS_ADDR_ENABLE, 32'h0000_0000);
		hst.rd(ORS_ADDR_FLAGS, d);
		`CHK("flagwr", {16'h0000, fl, 6'h00}, d)
		hst.rd(ORS_ADDR_ENABLE, d);
		`CHK("enwr", {16'h0000, cfg, 6'h00}, d)
		$display("test events done");
		hst.wr(ORS_ADDR_RANGE, 32'h0012_3456);
		act = 10'h3ff;
		@(negedge clk);
		rst_n = 1'b0;
		act = 10'h000;
		@(negedge clk);
		rst_n = 1'b1;
		`CHK("flagrst", 16'h0000, flags)
		hst.rd(ORS_ADDR_RANGE, d);
		`CHK("rangerst", 32'h0000_0000, d)
		$display("test midreset done");
		results;
	end
endmodule
